/* File: rtl/cnm_pkg.sv */
// shared constants and types of the canopen node monitor and transmit pdo block
package cnm_pkg;
	// object dictionary indices
	localparam logic [15:0] IDX_GUARD = 16'h100c;
	localparam logic [15:0] IDX_LIFE = 16'h100d;
	localparam logic [15:0] IDX_CONS = 16'h1016;
	localparam logic [15:0] IDX_HBPROD = 16'h1017;
	localparam logic [15:0] IDX_TPDO1 = 16'h1800;
	// sub-indices
	localparam logic [7:0] SUB_ZERO = 8'h00;
	localparam logic [7:0] SUB_ONE = 8'h01;
	localparam logic [7:0] SUB_TWO = 8'h02;
	localparam logic [7:0] SUB_EVT = 8'h05;
	// read-only values
	localparam logic [7:0] CONS_COUNT = 8'h02;
	localparam logic [7:0] TPDO_TOPSUB = 8'h05;
	// values after reset
	localparam logic [15:0] GUARD_RST = 16'h0000;
	localparam logic [7:0] LIFE_RST = 8'h00;
	localparam logic [31:0] CONS_RST = 32'h0000_0000;
	localparam logic [15:0] HBPROD_RST = 16'h0000;
	localparam logic [7:0] TTYPE_RST = 8'h01;
	localparam logic [15:0] EVT_RST = 16'h0000;
	// frame identifiers
	localparam logic [10:0] HB_BASE = 11'h700;
	localparam logic [10:0] EMCY_BASE = 11'h080;
	localparam logic [10:0] SYNC_ID = 11'h080;
	localparam logic [28:0] TPDO1_BASE = 29'h180;
	// network states
	localparam logic [7:0] NS_BOOT = 8'h00;
	localparam logic [7:0] NS_STOPPED = 8'h04;
	localparam logic [7:0] NS_OPER = 8'h05;
	localparam logic [7:0] NS_PREOP = 8'h7f;
	// emergency payload
	localparam logic [15:0] EMCY_CODE = 16'h8130;
	localparam logic [7:0] EMCY_ERREG = 8'h11;
	// transmission types
	localparam logic [7:0] TT_ACYC = 8'h00;
	localparam logic [7:0] TT_CYC_MAX = 8'hf0;
	localparam logic [7:0] TT_RTR_SYNC = 8'hfc;
	localparam logic [7:0] TT_RTR_ASYNC = 8'hfd;
	localparam logic [7:0] TT_EVENT = 8'hff;
	// identifier word and consumer entry fields
	localparam int COB_VALID_BIT = 31;
	localparam int COB_RTR_BIT = 30;
	localparam int COB_EXT_BIT = 29;
	localparam int CONS_NODE_LSB = 16;
	localparam logic [7:0] NODE_MAX = 8'h7f;
	// frame lengths
	localparam logic [3:0] DLC_HB = 4'h1;
	localparam logic [3:0] DLC_FULL = 4'h8;
	// timing: 1 ms base at 200 MHz
	localparam int CLK_HZ = 200_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	// transmit queue
	localparam int FRAME_W = 98;
	localparam int FIFO_DEPTH = 32;
	// boot sequence
	typedef enum logic [2:0] {
		BST_WAIT = 3'b001,
		BST_SEND = 3'b010,
		BST_RUN = 3'b100
	} cnm_boot_t;
endpackage

/* File: rtl/cnm_ms_tick.sv */
// one-cycle enable pulse every millisecond
`timescale 1ns/100ps
module cnm_ms_tick #(
	parameter int CYCLES = cnm_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	output logic tick
);
	logic [31:0] cnt_r;

	// free running divider
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_r <= 32'h0;
			tick <= 1'b0;
		end else if (cnt_r >= 32'(CYCLES - 1)) begin
			cnt_r <= 32'h0;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule

/* File: rtl/cnm_frame_fifo.sv */
// frame queue with valid and ready on both sides
`timescale 1ns/100ps
module cnm_frame_fifo #(
	parameter int W = cnm_pkg::FRAME_W,
	parameter int DEPTH = cnm_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_r;
	logic [AW:0] rdPtr_r;
	logic full;
	logic empty;

	// full when pointers differ only in the wrap bit
	assign empty = (wrPtr_r == rdPtr_r);
	assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[rdPtr_r[AW-1:0]];

	// storage write
	always_ff @(posedge clk) begin
		if (inValid && !full) begin
			mem[wrPtr_r[AW-1:0]] <= inData;
		end
	end

	// pointers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
		end else begin
			if (inValid && !full) begin
				wrPtr_r <= wrPtr_r + (AW + 1)'(1);
			end
			if (outReady && !empty) begin
				rdPtr_r <= rdPtr_r + (AW + 1)'(1);
			end
		end
	end
endmodule

/* File: rtl/cnm_node_monitor.sv */
// heartbeat, node guarding and transmit pdo 1 of a canopen counter node
// Function
// - heartbeat identifier is 700h plus node address, fixed
// - heartbeat carries one byte, the node state code
// - after reset and init, send one boot-up frame with state zero
// - heartbeat repeats every producer time in ms; zero disables it
// - two remote producers watched; a missed heartbeat sends emergency 8130h
// - consumer entry: zero byte, node address byte, 16-bit time
// - entry unused when time zero, node zero or node above 127
// - consumer time in ms; watching starts after first heartbeat
// - producer time reaches non-volatile storage only on store command
// - producer time object accepts sub-index zero only, else error
// - master polls at guard intervals; node answers with its state
// - lifetime is guard time times factor; unpolled lifetime raises event
// - life guarding error sends emergency 8130h
// - guard time is 16 bits in ms; zero disables guarding
// - life time factor is 8 bits, default zero; zero disables guarding
// - process data is sent only while operational
// - types FCh and FDh rejected; identifier bit 30 always reads one
// - identifier defaults to 180h plus node; bits 31,30,29,28-0 fields
// - bit 31 clear enables the pdo; enabled after reset
// - type 00h acyclic sync, 01h-F0h cyclic sync, FFh event timer
// - pdo parameter object accepts sub-indices 0 to 2 and 5 only
// - pdo carries 8 bytes: frequency of channel 1 then channel 2
// - frequencies are unsigned, 0.1 Hz per count
// - synchronous types send the pdo on sync reception
`timescale 1ns/100ps
module cnm_node_monitor #(
	parameter int TICK_CYCLES = cnm_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [6:0] nodeAddr,
	input wire logic initDone,
	input wire logic [7:0] netState,
	input wire logic rxValid,
	input wire logic [10:0] rxId,
	input wire logic rxRtr,
	input wire logic [31:0] freqCh1,
	input wire logic [31:0] freqCh2,
	input wire logic odReq,
	input wire logic odWrite,
	input wire logic [15:0] odIndex,
	input wire logic [7:0] odSub,
	input wire logic [31:0] odWdata,
	output logic odAck,
	output logic odErr,
	output logic [31:0] odRdata,
	input wire logic storeCmd,
	output logic nvWrite,
	output logic [15:0] nvData,
	output logic txValid,
	input wire logic txReady,
	output logic [28:0] txId,
	output logic txExt,
	output logic [3:0] txDlc,
	output logic [63:0] txData,
	output logic lifeGuardEvent,
	output logic [1:0] consumerFail
);
	logic msTick;
	logic [15:0] guard_r;
	logic [7:0] life_r;
	logic [31:0] cons_r [2];
	logic [15:0] hbPeriod_r;
	logic cobValid_r;
	logic cobExt_r;
	logic cobUser_r;
	logic [28:0] cobId_r;
	logic [7:0] tType_r;
	logic [15:0] evtPeriod_r;
	cnm_pkg::cnm_boot_t bootSt_r;
	logic emcyPend_r, guardPend_r, hbPend_r, pdoPend_r;
	logic [15:0] hbCnt_r;
	logic [23:0] lifeCnt_r;
	logic polled_r;
	logic toggle_r;
	logic [1:0] consArmed_r;
	logic [15:0] consCnt_r [2];
	logic [1:0] consUsed, consRx, consFail;
	logic [7:0] syncCnt_r;
	logic [15:0] evtCnt_r;
	logic [63:0] lastSent_r;
	logic [28:0] effId;
	logic wrOk, pollRx, syncRx, lifeOn, lifeFail, hbFire, pdoFire, pdoEn;
	logic [23:0] lifeTime;
	logic selBoot, selEmcy, selGuard, selHb, selPdo, push, fifoInReady;
	localparam int FRAMEW = cnm_pkg::FRAME_W;
	logic [FRAMEW-1:0] pushFrame;

	// checks an object access; true when it must be answered without error
	function automatic logic odOk(input logic [15:0] idx, input logic [7:0] sub,
		input logic wr, input logic [31:0] wd);
		odOk = 1'b0;
		case (idx)
			cnm_pkg::IDX_GUARD, cnm_pkg::IDX_LIFE, cnm_pkg::IDX_HBPROD: begin
				odOk = (sub == cnm_pkg::SUB_ZERO);
			end
			cnm_pkg::IDX_CONS: begin
				odOk = (sub == cnm_pkg::SUB_ZERO && !wr) || sub == cnm_pkg::SUB_ONE ||
					sub == cnm_pkg::SUB_TWO;
			end
			cnm_pkg::IDX_TPDO1: begin
				odOk = (sub == cnm_pkg::SUB_ZERO && !wr) || sub == cnm_pkg::SUB_ONE ||
					sub == cnm_pkg::SUB_EVT || (sub == cnm_pkg::SUB_TWO && !(wr &&
					(wd[7:0] == cnm_pkg::TT_RTR_SYNC || wd[7:0] == cnm_pkg::TT_RTR_ASYNC)));
			end
			default: begin
				odOk = 1'b0;
			end
		endcase
	endfunction

	cnm_ms_tick #(.CYCLES(TICK_CYCLES)) i_cnm_ms_tick (
		.clk(clk),
		.rstn(rstn),
		.tick(msTick)
	);

	assign wrOk = odReq && odWrite && odOk(odIndex, odSub, odWrite, odWdata);
	assign effId = cobUser_r ? cobId_r : cnm_pkg::TPDO1_BASE + 29'(nodeAddr);

	// object writes
	always_ff @(posedge clk) begin
		if (!rstn) begin
			guard_r <= cnm_pkg::GUARD_RST;
			life_r <= cnm_pkg::LIFE_RST;
			cons_r[0] <= cnm_pkg::CONS_RST;
			cons_r[1] <= cnm_pkg::CONS_RST;
			hbPeriod_r <= cnm_pkg::HBPROD_RST;
			cobValid_r <= 1'b0;
			cobExt_r <= 1'b0;
			cobUser_r <= 1'b0;
			cobId_r <= 29'h0;
			tType_r <= cnm_pkg::TTYPE_RST;
			evtPeriod_r <= cnm_pkg::EVT_RST;
		end else if (wrOk) begin
			case (odIndex)
				cnm_pkg::IDX_GUARD: guard_r <= odWdata[15:0];
				cnm_pkg::IDX_LIFE: life_r <= odWdata[7:0];
				cnm_pkg::IDX_HBPROD: hbPeriod_r <= odWdata[15:0];
				cnm_pkg::IDX_CONS: begin
					cons_r[odSub[1]] <= {8'h00, odWdata[23:0]};
				end
				cnm_pkg::IDX_TPDO1: begin
					if (odSub == cnm_pkg::SUB_ONE) begin
						cobValid_r <= odWdata[cnm_pkg::COB_VALID_BIT];
						cobExt_r <= odWdata[cnm_pkg::COB_EXT_BIT];
						cobId_r <= odWdata[28:0];
						cobUser_r <= 1'b1;
					end else if (odSub == cnm_pkg::SUB_TWO) begin
						tType_r <= odWdata[7:0];
					end else begin
						evtPeriod_r <= odWdata[15:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// object read answer, one cycle after the request
	always_ff @(posedge clk) begin
		if (!rstn) begin
			odAck <= 1'b0;
			odErr <= 1'b0;
			odRdata <= 32'h0;
		end else begin
			odAck <= odReq;
			odErr <= odReq && !odOk(odIndex, odSub, odWrite, odWdata);
			odRdata <= 32'h0;
			if (odReq && !odWrite) begin
				case (odIndex)
					cnm_pkg::IDX_GUARD: odRdata <= {16'h0, guard_r};
					cnm_pkg::IDX_LIFE: odRdata <= {24'h0, life_r};
					cnm_pkg::IDX_HBPROD: odRdata <= {16'h0, hbPeriod_r};
					cnm_pkg::IDX_CONS: begin
						odRdata <= (odSub == cnm_pkg::SUB_ZERO) ?
							{24'h0, cnm_pkg::CONS_COUNT} : cons_r[odSub[1]];
					end
					cnm_pkg::IDX_TPDO1: begin
						case (odSub)
							cnm_pkg::SUB_ZERO: odRdata <= {24'h0, cnm_pkg::TPDO_TOPSUB};
							cnm_pkg::SUB_ONE: odRdata <= {cobValid_r, 1'b1, cobExt_r, effId};
							cnm_pkg::SUB_TWO: odRdata <= {24'h0, tType_r};
							default: odRdata <= {16'h0, evtPeriod_r};
						endcase
					end
					default: odRdata <= 32'h0;
				endcase
			end
		end
	end

	// producer time goes to non-volatile storage only on the store command
	always_ff @(posedge clk) begin
		if (!rstn) begin
			nvWrite <= 1'b0;
			nvData <= cnm_pkg::HBPROD_RST;
		end else begin
			nvWrite <= storeCmd;
			if (storeCmd) begin
				nvData <= hbPeriod_r;
			end
		end
	end

	// boot sequence: wait for init, send boot-up once, then run
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bootSt_r <= cnm_pkg::BST_WAIT;
		end else begin
			case (bootSt_r)
				cnm_pkg::BST_WAIT: if (initDone) bootSt_r <= cnm_pkg::BST_SEND;
				cnm_pkg::BST_SEND: if (push) bootSt_r <= cnm_pkg::BST_RUN;
				cnm_pkg::BST_RUN: bootSt_r <= cnm_pkg::BST_RUN;
				default: bootSt_r <= cnm_pkg::BST_WAIT;
			endcase
		end
	end

	// heartbeat period counter
	assign hbFire = msTick && hbPeriod_r != 16'h0 && (17'(hbCnt_r) + 17'h1 >= 17'(hbPeriod_r));
	always_ff @(posedge clk) begin
		if (!rstn || hbPeriod_r == 16'h0) begin
			hbCnt_r <= 16'h0;
		end else if (msTick) begin
			hbCnt_r <= hbFire ? 16'h0 : hbCnt_r + 16'h1;
		end
	end

	// heartbeat consumers
	generate
		for (genvar gi = 0; gi < 2; gi++) begin : g_cons
			logic [7:0] cNode;
			logic [15:0] cTime;
			assign cNode = cons_r[gi][23:16];
			assign cTime = cons_r[gi][15:0];
			assign consUsed[gi] = cTime != 16'h0 && cNode != 8'h0 && cNode <= cnm_pkg::NODE_MAX;
			assign consRx[gi] = rxValid && !rxRtr && rxId == cnm_pkg::HB_BASE + 11'(cNode);
			assign consFail[gi] = consUsed[gi] && consArmed_r[gi] && !consRx[gi] && msTick &&
				(17'(consCnt_r[gi]) + 17'h1 >= 17'(cTime));
			always_ff @(posedge clk) begin
				if (!rstn || !consUsed[gi]) begin
					consArmed_r[gi] <= 1'b0;
					consCnt_r[gi] <= 16'h0;
				end else if (consRx[gi]) begin
					consArmed_r[gi] <= 1'b1;
					consCnt_r[gi] <= 16'h0;
				end else if (consFail[gi]) begin
					consArmed_r[gi] <= 1'b0;
					consCnt_r[gi] <= 16'h0;
				end else if (consArmed_r[gi] && msTick) begin
					consCnt_r[gi] <= consCnt_r[gi] + 16'h1;
				end
			end
		end
	endgenerate

	// life guarding supervision
	assign lifeTime = 24'(guard_r) * 24'(life_r);
	assign lifeOn = guard_r != 16'h0 && life_r != 8'h0;
	assign pollRx = rxValid && rxRtr && rxId == cnm_pkg::HB_BASE + 11'(nodeAddr);
	assign lifeFail = lifeOn && polled_r && !pollRx && msTick &&
		(25'(lifeCnt_r) + 25'h1 >= 25'(lifeTime));
	always_ff @(posedge clk) begin
		if (!rstn || !lifeOn) begin
			polled_r <= 1'b0;
			lifeCnt_r <= 24'h0;
		end else if (pollRx) begin
			polled_r <= 1'b1;
			lifeCnt_r <= 24'h0;
		end else if (lifeFail) begin
			polled_r <= 1'b0;
			lifeCnt_r <= 24'h0;
		end else if (polled_r && msTick) begin
			lifeCnt_r <= lifeCnt_r + 24'h1;
		end
	end

	// guard answer toggle flips with each answer sent
	always_ff @(posedge clk) begin
		if (!rstn) begin
			toggle_r <= 1'b0;
		end else if (push && selGuard) begin
			toggle_r <= !toggle_r;
		end
	end

	// pdo triggers
	assign pdoEn = !cobValid_r && netState == cnm_pkg::NS_OPER;
	assign syncRx = rxValid && !rxRtr && rxId == cnm_pkg::SYNC_ID;
	always_comb begin
		pdoFire = 1'b0;
		if (tType_r == cnm_pkg::TT_ACYC) begin
			pdoFire = syncRx && {freqCh2, freqCh1} != lastSent_r;
		end else if (tType_r <= cnm_pkg::TT_CYC_MAX) begin
			pdoFire = syncRx && (syncCnt_r + 8'h1 >= tType_r);
		end else if (tType_r == cnm_pkg::TT_EVENT) begin
			pdoFire = msTick && evtPeriod_r != 16'h0 && (evtCnt_r + 16'h1 >= evtPeriod_r);
		end
	end

	// sync and event timer counters
	always_ff @(posedge clk) begin
		if (!rstn) begin
			syncCnt_r <= 8'h0;
			evtCnt_r <= 16'h0;
		end else begin
			if (syncRx) begin
				syncCnt_r <= pdoFire ? 8'h0 : syncCnt_r + 8'h1;
			end
			if (tType_r != cnm_pkg::TT_EVENT || evtPeriod_r == 16'h0) begin
				evtCnt_r <= 16'h0;
			end else if (msTick) begin
				evtCnt_r <= pdoFire ? 16'h0 : evtCnt_r + 16'h1;
			end
		end
	end

	// pending frames: a new event wins over the clear by sending
	always_ff @(posedge clk) begin
		if (!rstn) begin
			emcyPend_r <= 1'b0;
			guardPend_r <= 1'b0;
			hbPend_r <= 1'b0;
			pdoPend_r <= 1'b0;
			lastSent_r <= 64'h0;
		end else begin
			emcyPend_r <= (emcyPend_r && !(push && selEmcy)) || (|consFail) || lifeFail;
			guardPend_r <= (guardPend_r && !(push && selGuard)) || pollRx;
			hbPend_r <= (hbPend_r && !(push && selHb)) || hbFire;
			pdoPend_r <= pdoEn && ((pdoPend_r && !(push && selPdo)) || pdoFire);
			if (push && selPdo) begin
				lastSent_r <= {freqCh2, freqCh1};
			end
		end
	end

	// event outputs
	always_ff @(posedge clk) begin
		if (!rstn) begin
			lifeGuardEvent <= 1'b0;
			consumerFail <= 2'b00;
		end else begin
			lifeGuardEvent <= lifeFail;
			consumerFail <= consFail;
		end
	end

	// frame selection: boot-up first, then emergency, guard, heartbeat, pdo
	assign selBoot = bootSt_r == cnm_pkg::BST_SEND;
	assign selEmcy = bootSt_r == cnm_pkg::BST_RUN && emcyPend_r;
	assign selGuard = bootSt_r == cnm_pkg::BST_RUN && !emcyPend_r && guardPend_r;
	assign selHb = bootSt_r == cnm_pkg::BST_RUN && !emcyPend_r && !guardPend_r && hbPend_r;
	assign selPdo = bootSt_r == cnm_pkg::BST_RUN && !emcyPend_r && !guardPend_r &&
		!hbPend_r && pdoPend_r && pdoEn;
	assign push = (selBoot || selEmcy || selGuard || selHb || selPdo) && fifoInReady;

	// frame image: identifier, extended flag, length, payload byte 0 lowest
	always_comb begin
		pushFrame = '0;
		if (selBoot) begin
			pushFrame = {29'(cnm_pkg::HB_BASE + 11'(nodeAddr)), 1'b0, cnm_pkg::DLC_HB,
				56'h0, cnm_pkg::NS_BOOT};
		end else if (selEmcy) begin
			pushFrame = {29'(cnm_pkg::EMCY_BASE + 11'(nodeAddr)), 1'b0, cnm_pkg::DLC_FULL,
				40'h0, cnm_pkg::EMCY_ERREG, cnm_pkg::EMCY_CODE};
		end else if (selGuard) begin
			pushFrame = {29'(cnm_pkg::HB_BASE + 11'(nodeAddr)), 1'b0, cnm_pkg::DLC_HB,
				56'h0, toggle_r, netState[6:0]};
		end else if (selHb) begin
			pushFrame = {29'(cnm_pkg::HB_BASE + 11'(nodeAddr)), 1'b0, cnm_pkg::DLC_HB,
				56'h0, netState};
		end else if (selPdo) begin
			pushFrame = {effId, cobExt_r, cnm_pkg::DLC_FULL, freqCh2, freqCh1};
		end
	end

	cnm_frame_fifo #(.W(FRAMEW), .DEPTH(cnm_pkg::FIFO_DEPTH)) i_cnm_frame_fifo (
		.clk(clk),
		.rstn(rstn),
		.inValid(selBoot || selEmcy || selGuard || selHb || selPdo),
		.inReady(fifoInReady),
		.inData(pushFrame),
		.outValid(txValid),
		.outReady(txReady),
		.outData({txId, txExt, txDlc, txData})
	);

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_hbId;
		push && selHb |-> pushFrame[97:69] == 29'(cnm_pkg::HB_BASE + 11'(nodeAddr));
	endproperty
	a_hbId: assert property (p_hbId) else $error("heartbeat id wrong");

	property p_hbByte;
		push && selHb |-> pushFrame[67:64] == cnm_pkg::DLC_HB && pushFrame[7:0] == netState;
	endproperty
	a_hbByte: assert property (p_hbByte) else $error("heartbeat byte wrong");

	property p_bootOnce;
		push && selBoot |-> pushFrame[7:0] == cnm_pkg::NS_BOOT ##1 bootSt_r == cnm_pkg::BST_RUN;
	endproperty
	a_bootOnce: assert property (p_bootOnce) else $error("boot-up not single");

	property p_hbOff;
		$rose(hbPend_r) |-> $past(hbPeriod_r) != 16'h0 && $past(msTick);
	endproperty
	a_hbOff: assert property (p_hbOff) else $error("heartbeat while disabled");

	property p_consEmcy;
		|consFail |=> emcyPend_r ##[0:40] (push && selEmcy);
	endproperty
	a_consEmcy: assert property (p_consEmcy) else $error("no emergency on consumer loss");

	property p_consIgnore;
		!consUsed[0] |=> !consArmed_r[0];
	endproperty
	a_consIgnore: assert property (p_consIgnore) else $error("unused entry watched");

	property p_pollAnswer;
		pollRx |=> guardPend_r;
	endproperty
	a_pollAnswer: assert property (p_pollAnswer) else $error("poll not answered");

	property p_lifeEvent;
		lifeFail |=> lifeGuardEvent && emcyPend_r && !polled_r;
	endproperty
	a_lifeEvent: assert property (p_lifeEvent) else $error("life guard event missing");

	property p_pdoOper;
		push && selPdo |-> netState == cnm_pkg::NS_OPER && !cobValid_r;
	endproperty
	a_pdoOper: assert property (p_pdoOper) else $error("pdo outside operational");

	property p_rtrType;
		odReq && odWrite && odIndex == cnm_pkg::IDX_TPDO1 && odSub == cnm_pkg::SUB_TWO &&
			odWdata[7:0] == cnm_pkg::TT_RTR_SYNC |=> odErr && tType_r == $past(tType_r);
	endproperty
	a_rtrType: assert property (p_rtrType) else $error("rtr type accepted");
endmodule

/* File: testbench/cnm_net_partner.sv */
// network-side model: frame source on the receive port, frame sink on the transmit port
`timescale 1ns/100ps
module cnm_net_partner (
	input wire logic clk,
	output logic rxValid,
	output logic [10:0] rxId,
	output logic rxRtr,
	input wire logic txValid,
	output logic txReady,
	input wire logic [28:0] txId,
	input wire logic txExt,
	input wire logic [3:0] txDlc,
	input wire logic [63:0] txData
);
	// idle bus at time zero
	initial begin
		rxValid = 1'b0;
		rxId = 11'h000;
		rxRtr = 1'b0;
		txReady = 1'b0;
	end
	// one frame for one cycle, then lines scrambled so stale values never pass
	task automatic sendFrame(input logic [10:0] id, input logic rtr);
		@(negedge clk);
		rxValid = 1'b1;
		rxId = id;
		rxRtr = rtr;
		@(negedge clk);
		rxValid = 1'b0;
		rxId = ~id;
		rxRtr = ~rtr;
	endtask
	// master guard poll is a remote frame on the node's heartbeat id
	task automatic poll(input logic [10:0] id);
		sendFrame(id, 1'b1);
	endtask
	// take the head frame; ok stays low when none shows up in time
	task automatic getFrame(output logic ok, output logic [28:0] id, output logic ext,
		output logic [3:0] dlc, output logic [63:0] data);
		ok = 1'b0;
		for (int i = 0; i < 400 && !ok; i++) begin
			@(negedge clk);
			ok = (txValid === 1'b1);
		end
		id = txId;
		ext = txExt;
		dlc = txDlc;
		data = txData;
		txReady = ok;
		@(negedge clk);
		txReady = 1'b0;
	endtask
endmodule

/* File: testbench/cnm_node_monitor_bench.sv */
// self-checking bench of the node monitor with the network partner
`timescale 1ns/100ps
module cnm_node_monitor_bench;
	logic clk, rstn, initDone, rxValid, rxRtr, odReq, odWrite, odAck, odErr, storeCmd, nvWrite;
	logic txValid, txReady, txExt, lifeGuardEvent, fOk, fExt, lifeSeen;
	logic [7:0] netState, odSub;
	logic [10:0] rxId;
	logic [15:0] odIndex, nvData;
	logic [31:0] freqCh1, freqCh2, odWdata, odRdata;
	logic [28:0] txId, fId;
	logic [3:0] txDlc, fDlc;
	logic [63:0] txData, fData;
	logic [1:0] consumerFail, failSeen;
	logic [7:0] states [3] = '{8'h04, 8'h05, 8'h7f};
	int errTotal = 0;
	int comparisons = 0;
	int cycles = 0;
	localparam logic [63:0] EMCY = 64'h0000_0000_0011_8130;
	cnm_node_monitor #(.TICK_CYCLES(20)) i_cnm_node_monitor (.clk(clk), .rstn(rstn),
		.nodeAddr(7'h01), .initDone(initDone), .netState(netState), .rxValid(rxValid),
		.rxId(rxId), .rxRtr(rxRtr), .freqCh1(freqCh1), .freqCh2(freqCh2), .odReq(odReq),
		.odWrite(odWrite), .odIndex(odIndex), .odSub(odSub), .odWdata(odWdata), .odAck(odAck),
		.odErr(odErr), .odRdata(odRdata), .storeCmd(storeCmd), .nvWrite(nvWrite),
		.nvData(nvData), .txValid(txValid), .txReady(txReady), .txId(txId), .txExt(txExt),
		.txDlc(txDlc), .txData(txData), .lifeGuardEvent(lifeGuardEvent),
		.consumerFail(consumerFail));
	cnm_net_partner i_cnm_net_partner (.clk(clk), .rxValid(rxValid), .rxId(rxId),
		.rxRtr(rxRtr), .txValid(txValid), .txReady(txReady), .txId(txId), .txExt(txExt),
		.txDlc(txDlc), .txData(txData));
	// 200 mhz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// sticky event flags and hang guard
	always @(posedge clk) begin
		failSeen <= rstn ? (failSeen | consumerFail) : 2'h0;
		lifeSeen <= rstn ? (lifeSeen | lifeGuardEvent) : 1'b0;
		cycles++;
		if (cycles == 8000) begin
			errTotal++;
			results();
		end
	end
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errTotal++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one object access, answer checked one cycle later
	task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, input logic expErr, input logic [31:0] expRd);
		@(negedge clk);
		odReq = 1'b1;
		odWrite = wr;
		odIndex = idx;
		odSub = sub;
		odWdata = wd;
		@(negedge clk);
		odReq = 1'b0;
		check("odAck", odAck, 1'b1);
		check("odErr", odErr, expErr);
		if (!wr && !expErr) check("odRdata", odRdata, expRd);
	endtask
	// pop a frame; single-byte frames compare byte 0 only
	task automatic frame(input logic [28:0] id, input logic [3:0] dlc, input logic [63:0] data);
		i_cnm_net_partner.getFrame(fOk, fId, fExt, fDlc, fData);
		check("txPresent", fOk, 1'b1);
		check("txId", fId, id);
		check("txExt", fExt, 1'b0);
		check("txDlc", fDlc, dlc);
		check("txData", (dlc == 4'h1) ? {56'h0, fData[7:0]} : fData, data);
	endtask
	task automatic quiet(input int n);
		repeat (n) @(negedge clk);
		check("txIdle", txValid, 1'b0);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		{rstn, initDone, odReq, odWrite, storeCmd} = 5'h00;
		netState = 8'h7f;
		{odIndex, odSub, odWdata} = 56'h0;
		freqCh1 = 32'h0000_2c4c;
		freqCh2 = 32'h1234_5678;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		od(0, 16'h100c, 8'h00, 32'h0, 0, 32'h0);
		od(0, 16'h100d, 8'h00, 32'h0, 0, 32'h0);
		od(0, 16'h1016, 8'h00, 32'h0, 0, 32'h2);
		od(0, 16'h1017, 8'h00, 32'h0, 0, 32'h0);
		od(0, 16'h1800, 8'h00, 32'h0, 0, 32'h5);
		od(0, 16'h1800, 8'h01, 32'h0, 0, 32'h4000_0181);
		od(0, 16'h1800, 8'h05, 32'h0, 0, 32'h0);
		od(1, 16'h1017, 8'h01, 32'h5, 1, 32'h0);
		od(0, 16'h1800, 8'h03, 32'h0, 1, 32'h0);
		od(0, 16'h2000, 8'h00, 32'h0, 1, 32'h0);
		od(1, 16'h1800, 8'h02, 32'hfc, 1, 32'h0);
		od(1, 16'h1800, 8'h02, 32'hfd, 1, 32'h0);
		od(0, 16'h1800, 8'h02, 32'h0, 0, 32'h1);
		$display("test registers done");
		initDone = 1'b1;
		frame(29'h701, 4'h1, 64'h0);
		od(1, 16'h1017, 8'h00, 32'h2, 0, 32'h0);
		check("nvWrite", nvWrite, 1'b0);
		storeCmd = 1'b1;
		@(negedge clk);
		storeCmd = 1'b0;
		check("nvWrite", nvWrite, 1'b1);
		check("nvData", nvData, 16'h0002);
		foreach (states[i]) begin
			netState = states[i];
			frame(29'h701, 4'h1, {56'h0, states[i]});
		end
		od(1, 16'h1017, 8'h00, 32'h0, 0, 32'h0);
		quiet(60);
		$display("test heartbeat done");
		netState = 8'h05;
		i_cnm_net_partner.sendFrame(11'h080, 1'b0);
		frame(29'h181, 4'h8, {freqCh2, freqCh1});
		od(1, 16'h1800, 8'h05, 32'h1, 0, 32'h0);
		od(1, 16'h1800, 8'h02, 32'hff, 0, 32'h0);
		frame(29'h181, 4'h8, {freqCh2, freqCh1});
		od(1, 16'h1800, 8'h01, 32'h8000_0181, 0, 32'h0);
		od(1, 16'h1800, 8'h02, 32'h01, 0, 32'h0);
		i_cnm_net_partner.sendFrame(11'h080, 1'b0);
		quiet(30);
		od(1, 16'h1800, 8'h01, 32'h0000_0181, 0, 32'h0);
		od(0, 16'h1800, 8'h01, 32'h0, 0, 32'h4000_0181);
		// acyclic type: a sync with unchanged data sends nothing, changed data is sent
		od(1, 16'h1800, 8'h02, 32'h00, 0, 32'h0);
		i_cnm_net_partner.sendFrame(11'h080, 1'b0);
		quiet(30);
		freqCh1 = 32'h0000_2c4d;
		i_cnm_net_partner.sendFrame(11'h080, 1'b0);
		frame(29'h181, 4'h8, {freqCh2, freqCh1});
		od(1, 16'h1800, 8'h02, 32'h01, 0, 32'h0);
		netState = 8'h7f;
		i_cnm_net_partner.sendFrame(11'h080, 1'b0);
		quiet(30);
		$display("test pdo done");
		od(1, 16'h100c, 8'h00, 32'h1, 0, 32'h0);
		od(1, 16'h100d, 8'h00, 32'h2, 0, 32'h0);
		i_cnm_net_partner.poll(11'h701);
		frame(29'h701, 4'h1, 64'h7f);
		i_cnm_net_partner.poll(11'h701);
		frame(29'h701, 4'h1, 64'hff);
		frame(29'h081, 4'h8, EMCY);
		check("lifeEvent", lifeSeen, 1'b1);
		od(1, 16'h100c, 8'h00, 32'h0, 0, 32'h0);
		$display("test guarding done");
		od(1, 16'h1016, 8'h01, 32'hff05_0003, 0, 32'h0);
		od(0, 16'h1016, 8'h01, 32'h0, 0, 32'h0005_0003);
		quiet(100);
		i_cnm_net_partner.sendFrame(11'h705, 1'b0);
		repeat (29) @(negedge clk);
		i_cnm_net_partner.sendFrame(11'h705, 1'b0);
		repeat (34) @(negedge clk);
		check("consumerFail", failSeen, 2'h0);
		frame(29'h081, 4'h8, EMCY);
		check("consumerFail", failSeen, 2'h1);
		od(1, 16'h1016, 8'h02, 32'h0080_0001, 0, 32'h0);
		i_cnm_net_partner.sendFrame(11'h780, 1'b0);
		quiet(80);
		$display("test consumer done");
		results();
	end
endmodule
